// ### common/rctc_pkg.sv
/*
  Constants for the RC oscillation touch converter: register offsets,
  field positions, reset values, response codes and timer sizing.
  Assumes a 32-bit AXI4-Lite bus with byte addresses and one word per register.
*/
package rctc_pkg;

  // Bus and data widths
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned TMR_W  = 16;
  localparam int unsigned SW_N   = 8;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CLK  = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_MASK = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_A_LO = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_A_HI = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_B_LO = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_B_HI = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_SW   = 8'h20;

  // Field positions
  localparam int unsigned CTRL_OVB_BIT = 0;
  localparam int unsigned CTRL_EN_BIT  = 1;
  localparam int unsigned CLK_RUN_BIT  = 4;
  localparam int unsigned CLK_SEL_LSB  = 5;
  localparam int unsigned CLK_SEL_W    = 3;
  localparam int unsigned IRQ_FLAG_BIT = 5;

  // Timer A clock select: this code runs on the system clock, any other on /4
  localparam logic [CLK_SEL_W-1:0] CLK_SEL_SYS = 3'h0;
  localparam int unsigned          DIV_A       = 4;

  // Reset values
  localparam logic [BYTE_W-1:0] CTRL_RST = 8'h00;
  localparam logic [BYTE_W-1:0] MASK_RST = 8'h00;
  localparam logic [BYTE_W-1:0] SW_RST   = 8'h00;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Register selector produced by the address decoder
  typedef enum {
    REG_CTRL, REG_CLK, REG_STAT, REG_MASK, REG_A_LO,
    REG_A_HI, REG_B_LO, REG_B_HI, REG_SW, REG_NONE
  } rctc_reg_e;

endpackage : rctc_pkg

// ### common/rctc_tmr_if.sv
/*
  Interface between the converter control logic and one 16-bit timer.
  Assumes both ends run on the same clock; strobes are one-cycle pulses.
*/
`timescale 1ns/100ps
`default_nettype none

interface rctc_tmr_if #(parameter int unsigned W = 16);
  logic         wr_lo;     // Byte write into the low buffer
  logic         wr_hi;     // Byte write into high half, buffer into low half
  logic         rd_hi;     // High byte read, freezes the low byte
  logic         inc;       // Count enable for this cycle
  logic [7:0]   wdata;
  logic [W-1:0] count;
  logic [7:0]   lo_latch;
  logic         ovf;       // All ones and incremented this cycle

  modport ctrl (output wr_lo, wr_hi, rd_hi, inc, wdata,
                input  count, lo_latch, ovf);
  modport tmr  (input  wr_lo, wr_hi, rd_hi, inc, wdata,
                output count, lo_latch, ovf);
endinterface : rctc_tmr_if

`default_nettype wire

// ### logic/rctc_timer.sv
/*
  One 16-bit up-counter with a low-byte write buffer and a low-byte read latch.
  Assumes the controller never writes while the counter is enabled.
*/
`timescale 1ns/100ps
`default_nettype none

module rctc_timer
  import rctc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  rctc_tmr_if.tmr  tmr
);

  logic [7:0]       wbuf_q;
  logic [TMR_W-1:0] count_q;
  logic [7:0]       latch_q;

  // Low byte writes only touch the buffer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wbuf_q <= 8'h00;
    end else if (tmr.wr_lo) begin
      wbuf_q <= tmr.wdata;
    end
  end

  // High write loads both halves at once; otherwise count up and wrap
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= '0;
    end else if (tmr.wr_hi) begin
      count_q <= {tmr.wdata, wbuf_q};
    end else if (tmr.inc) begin
      count_q <= count_q + 1'b1;
    end
  end

  // A high read freezes the low byte so the pair reads consistently
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latch_q <= 8'h00;
    end else if (tmr.rd_hi) begin
      latch_q <= count_q[7:0];
    end
  end

  // Overflow is the step from all ones to zero
  assign tmr.ovf      = tmr.inc && (count_q == '1);
  assign tmr.count    = count_q;
  assign tmr.lo_latch = latch_q;

endmodule : rctc_timer

`default_nettype wire

// ### logic/rctc_top.sv
/*
  RC oscillation touch converter with an AXI4-Lite register slave.
  Assumes rc_osc_in and all bus inputs are synchronous to aclk.
*/
// Our own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module rctc_top
  import rctc_pkg::*;
#(
  parameter int unsigned SW_LINES = SW_N
)(
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  input  wire logic [rctc_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [rctc_pkg::DATA_W-1:0]  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic [rctc_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic [rctc_pkg::DATA_W-1:0]       s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  input  wire logic                         rc_osc_in,
  output logic [SW_LINES-1:0]               touch_switch_lines,
  output logic                              irq
);

  import rctc_pkg::*;

  // Map a byte address onto a register; shared by both bus paths
  function automatic rctc_reg_e decode(input logic [ADDR_W-1:0] addr);
    rctc_reg_e r;
    r = REG_NONE;
    unique case (addr)
      OFS_CTRL: r = REG_CTRL;
      OFS_CLK:  r = REG_CLK;
      OFS_STAT: r = REG_STAT;
      OFS_MASK: r = REG_MASK;
      OFS_A_LO: r = REG_A_LO;
      OFS_A_HI: r = REG_A_HI;
      OFS_B_LO: r = REG_B_LO;
      OFS_B_HI: r = REG_B_HI;
      OFS_SW:   r = REG_SW;
      default:  r = REG_NONE;
    endcase
    return r;
  endfunction : decode

  // Timer byte registers share one refusal window with the run bit
  function automatic logic is_timer(input rctc_reg_e r);
    return (r == REG_A_LO) || (r == REG_A_HI) ||
           (r == REG_B_LO) || (r == REG_B_HI);
  endfunction : is_timer

  // Answer code shared by both bus paths; refused timer bytes get SLVERR
  function automatic logic [1:0] resp_of(input rctc_reg_e r, input logic run);
    if (r == REG_NONE) return RESP_DECERR;
    if (run && is_timer(r)) return RESP_SLVERR;
    return RESP_OKAY;
  endfunction : resp_of

  localparam int unsigned DIV_W = $clog2(DIV_A);

  // Timer ends
  rctc_tmr_if #(.W(TMR_W)) tmr_a ();
  rctc_tmr_if #(.W(TMR_W)) tmr_b ();
  // Bus state
  logic              awready_q;
  logic              wready_q;
  logic              aw_held_q;
  logic              w_held_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [BYTE_W-1:0] w_byte_q;
  logic              w_lane_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              arready_q;
  logic              rvalid_q;
  logic [1:0]        rresp_q;
  logic [DATA_W-1:0] rdata_q;
  // Converter state
  logic                 ovb_q;
  logic                 en_q;
  logic                 run_q;
  logic [CLK_SEL_W-1:0] clk_sel_q;
  logic [BYTE_W-1:0]    stat_q;
  logic [BYTE_W-1:0]    mask_q;
  logic [SW_LINES-1:0]  sw_q;
  logic                 irq_q;
  logic [DIV_W-1:0]     div_q;
  logic                 rc_q;
  // Combinational terms
  rctc_reg_e         wr_reg;
  rctc_reg_e         rd_reg;
  logic              do_wr;
  logic              wr_en;
  logic              rd_fire;
  logic              tick_a;
  logic              rc_rise;
  logic              ovf_any;
  logic              ovf_sel;
  logic [BYTE_W-1:0] rd_byte;

  rctc_timer u_tmr_a (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tmr     (tmr_a)
  );
  rctc_timer u_tmr_b (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tmr     (tmr_b)
  );

  // Write happens once address and data are both held and no answer waits
  assign wr_reg  = decode(aw_addr_q);
  assign do_wr   = aw_held_q && w_held_q && !bvalid_q;
  assign wr_en   = do_wr && w_lane_q && !(run_q && is_timer(wr_reg));
  assign rd_reg  = decode(s_axi_araddr);
  assign rd_fire = s_axi_arvalid && arready_q;

  // Write address channel: ready for one address while none is held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      aw_held_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (s_axi_awvalid && awready_q) begin
      awready_q <= 1'b0;
      aw_held_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (do_wr) begin
      aw_held_q <= 1'b0;
    end else if (!aw_held_q && !bvalid_q) begin
      awready_q <= 1'b1;
    end
  end

  // Write data channel: only the low lane carries register data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_q <= 1'b0;
      w_held_q <= 1'b0;
      w_byte_q <= '0;
      w_lane_q <= 1'b0;
    end else if (s_axi_wvalid && wready_q) begin
      wready_q <= 1'b0;
      w_held_q <= 1'b1;
      w_byte_q <= s_axi_wdata[BYTE_W-1:0];
      w_lane_q <= s_axi_wstrb[0];
    end else if (do_wr) begin
      w_held_q <= 1'b0;
    end else if (!w_held_q && !bvalid_q) begin
      wready_q <= 1'b1;
    end
  end

  // Write response: unmapped gets DECERR, refused timer access SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (do_wr) begin
      bvalid_q <= 1'b1;
      bresp_q  <= resp_of(wr_reg, run_q);
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Read address channel reopens only after the data beat is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
    end else if (rd_fire) begin
      arready_q <= 1'b0;
    end else if (!rvalid_q) begin
      arready_q <= 1'b1;
    end
  end

  // Read value mux; timer bytes read as zero while refused
  always_comb begin
    rd_byte = '0;
    unique case (rd_reg)
      REG_CTRL: begin
        rd_byte[CTRL_OVB_BIT] = ovb_q;
        rd_byte[CTRL_EN_BIT]  = en_q;
      end
      REG_CLK: begin
        rd_byte[CLK_RUN_BIT] = run_q;
        rd_byte[CLK_SEL_LSB +: CLK_SEL_W] = clk_sel_q;
      end
      REG_STAT: rd_byte = stat_q;
      REG_MASK: rd_byte = mask_q;
      REG_A_LO: rd_byte = run_q ? '0 : tmr_a.lo_latch;
      REG_A_HI: rd_byte = run_q ? '0 : tmr_a.count[TMR_W-1:BYTE_W];
      REG_B_LO: rd_byte = run_q ? '0 : tmr_b.lo_latch;
      REG_B_HI: rd_byte = run_q ? '0 : tmr_b.count[TMR_W-1:BYTE_W];
      REG_SW:   rd_byte = BYTE_W'(sw_q);
      REG_NONE: rd_byte = '0;
    endcase
  end

  // Read data channel: one beat, answered the cycle after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rresp_q  <= RESP_OKAY;
      rdata_q  <= '0;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rdata_q  <= DATA_W'(rd_byte);
      rresp_q  <= resp_of(rd_reg, run_q);
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Converter control register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ovb_q <= CTRL_RST[CTRL_OVB_BIT];
      en_q  <= CTRL_RST[CTRL_EN_BIT];
    end else if (wr_en && wr_reg == REG_CTRL) begin
      ovb_q <= w_byte_q[CTRL_OVB_BIT];
      en_q  <= w_byte_q[CTRL_EN_BIT];
    end
  end

  // Clock select field
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_sel_q <= CLK_SEL_SYS;
    end else if (wr_en && wr_reg == REG_CLK) begin
      clk_sel_q <= w_byte_q[CLK_SEL_LSB +: CLK_SEL_W];
    end
  end

  // Run bit: an overflow clears it even against a write in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_q <= 1'b0;
    end else if (ovf_any) begin
      run_q <= 1'b0;
    end else if (wr_en && wr_reg == REG_CLK) begin
      run_q <= w_byte_q[CLK_RUN_BIT];
    end
  end

  // Divide-by-four enable; restarts with each run so the first tick is whole
  always_ff @(posedge aclk) begin
    if (!aresetn || !run_q) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end
  assign tick_a = (clk_sel_q == CLK_SEL_SYS) ||
                  (div_q == DIV_W'(DIV_A - 1));

  // Oscillator rising edge; the pin is already synchronous to aclk
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rc_q <= 1'b0;
    end else begin
      rc_q <= rc_osc_in;
    end
  end
  assign rc_rise = rc_osc_in && !rc_q;

  // Both timers share one gate so they start and stop together
  always_comb begin
    tmr_a.inc   = run_q && en_q && tick_a;
    tmr_b.inc   = run_q && en_q && rc_rise;
    tmr_a.wdata = w_byte_q;
    tmr_b.wdata = w_byte_q;
    tmr_a.wr_lo = wr_en && (wr_reg == REG_A_LO);
    tmr_a.wr_hi = wr_en && (wr_reg == REG_A_HI);
    tmr_b.wr_lo = wr_en && (wr_reg == REG_B_LO);
    tmr_b.wr_hi = wr_en && (wr_reg == REG_B_HI);
    tmr_a.rd_hi = rd_fire && !run_q && (rd_reg == REG_A_HI);
    tmr_b.rd_hi = rd_fire && !run_q && (rd_reg == REG_B_HI);
  end

  // Either overflow halts the pair; only the selected one interrupts
  assign ovf_any = tmr_a.ovf || tmr_b.ovf;
  assign ovf_sel = ovb_q ? tmr_b.ovf : tmr_a.ovf;

  // Sticky status, cleared by a read; a new overflow wins over that clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_q <= '0;
    end else if (ovf_sel) begin
      stat_q[IRQ_FLAG_BIT] <= 1'b1;
    end else if (rd_fire && rd_reg == REG_STAT) begin
      stat_q <= '0;
    end
  end

  // Interrupt mask, same layout as status
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_q <= MASK_RST;
    end else if (wr_en && wr_reg == REG_MASK) begin
      mask_q <= w_byte_q;
    end
  end

  // Level interrupt, registered so the pin is glitch free
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(stat_q & mask_q);
    end
  end

  // Analog switch lines; a narrower variant keeps the low lines only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_q <= SW_LINES'(SW_RST);
    end else if (wr_en && wr_reg == REG_SW) begin
      sw_q <= SW_LINES'(w_byte_q);
    end
  end

  // Outputs straight from flip-flops
  assign s_axi_awready      = awready_q;
  assign s_axi_wready       = wready_q;
  assign s_axi_bvalid       = bvalid_q;
  assign s_axi_bresp        = bresp_q;
  assign s_axi_arready      = arready_q;
  assign s_axi_rvalid       = rvalid_q;
  assign s_axi_rresp        = rresp_q;
  assign s_axi_rdata        = rdata_q;
  assign touch_switch_lines = sw_q;
  assign irq                = irq_q;

endmodule : rctc_top

`default_nettype wire

// ### testbench/rctc_assertions.sv
/*
  Concurrent checks on the converter's bus answers, switch lines and irq.
  Assumes it is bound to rctc_top and sees only that module's ports.
*/
`timescale 1ns/100ps
`default_nettype none

module rctc_assertions
  import rctc_pkg::*;
#(
  parameter int unsigned SW_LINES = SW_N
)(
  input wire logic                        aclk,
  input wire logic                        aresetn,
  input wire logic [rctc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic                        s_axi_awvalid,
  input wire logic                        s_axi_awready,
  input wire logic [rctc_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0]                  s_axi_wstrb,
  input wire logic                        s_axi_wvalid,
  input wire logic                        s_axi_wready,
  input wire logic [1:0]                  s_axi_bresp,
  input wire logic                        s_axi_bvalid,
  input wire logic                        s_axi_bready,
  input wire logic [rctc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic                        s_axi_arvalid,
  input wire logic                        s_axi_arready,
  input wire logic [rctc_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0]                  s_axi_rresp,
  input wire logic                        s_axi_rvalid,
  input wire logic                        s_axi_rready,
  input wire logic                        rc_osc_in,
  input wire logic [SW_LINES-1:0]         touch_switch_lines,
  input wire logic                        irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Answers stand until the master takes them
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer dropped early");
  // Fixed answer latencies
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid && !s_axi_arready) else $error("read answer late");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer late");
  no_accept_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("new write taken during answer");
  // Byte-wide registers, refused reads give no data
  rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  refused_zero_a: assert property (
    s_axi_rvalid && s_axi_rresp != RESP_OKAY |-> s_axi_rdata == 32'h0000_0000)
    else $error("refused read returned data");
  // Switch lines move only when a write completes
  switch_write_a: assert property (
    !$stable(touch_switch_lines) |-> $rose(s_axi_bvalid)) else $error("switch lines moved");
  // Interrupt falls only in the cycle after a read answer or a write answer
  irq_sticky_a: assert property (
    $fell(irq) |-> $past(s_axi_rvalid) || $past(s_axi_bvalid)) else $error("irq fell alone");

  irq_seen_c: cover property ($rose(irq));
  slverr_c: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
  decerr_c: cover property (s_axi_rvalid && s_axi_rresp == RESP_DECERR);
endmodule : rctc_assertions

bind rctc_top rctc_assertions #(.SW_LINES(SW_LINES)) u_chk (.*);

`default_nettype wire

// ### testbench/rctc_rc_osc.sv
/*
  Behavioural touch-pad RC oscillator feeding the measurement timer.
  Assumes its output is sampled on aclk; it parks low while disabled.
*/
`timescale 1ns/100ps
`default_nettype none

module rctc_rc_osc #(
  parameter int unsigned HALF = 2
)(
  input wire logic  aclk,
  input wire logic  aresetn,
  input wire logic  osc_en,
  output var logic  rc_osc_in
);
  logic [7:0] cnt_q;

  // Square wave of 2*HALF cycles; held low when off so no stray edge counts
  always_ff @(posedge aclk) begin
    if (!aresetn || !osc_en) begin
      cnt_q <= 8'h00;
      rc_osc_in <= 1'b0;
    end else if (cnt_q == 8'(HALF - 1)) begin
      cnt_q <= 8'h00;
      rc_osc_in <= ~rc_osc_in;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule : rctc_rc_osc

`default_nettype wire

// ### testbench/rctc_top_tb.sv
/*
  Self-checking bench: AXI4-Lite register tasks and converter scenarios.
  Assumes rctc_top with default parameters and the RC oscillator model.
*/
`timescale 1ns/100ps
`default_nettype none

module rctc_top_tb;
  import rctc_pkg::*;
  logic                aclk = 1'b0;
  logic                aresetn = 1'b0;
  logic [ADDR_W-1:0]   s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [DATA_W-1:0]   s_axi_wdata = '0, s_axi_rdata, rd_v, v2;
  logic [3:0]          s_axi_wstrb = 4'hf;
  logic                s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic                s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, osc_en = 1'b0;
  logic                s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic                s_axi_rvalid, rc_osc_in, irq;
  logic [1:0]          s_axi_bresp, s_axi_rresp;
  logic [SW_N-1:0]     touch_switch_lines;
  int                  err_count = 0;
  int                  n_checks = 0;
  int                  n;
  logic [7:0]          rst_ofs [9] = '{OFS_CTRL, OFS_CLK, OFS_STAT, OFS_MASK, OFS_A_HI,
                                       OFS_A_LO, OFS_B_HI, OFS_B_LO, OFS_SW};

  rctc_top uut (.*);
  rctc_rc_osc osc (.aclk, .aresetn, .osc_en, .rc_osc_in);

  initial forever #10 aclk = ~aclk;

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done

  task automatic chk_val(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_checks++;
    if (got !== ex) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk_val

  task automatic chk_resp(input string nm, input logic [1:0] ex, input logic [1:0] got);
    n_checks++;
    if (got !== ex) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk_resp

  // One write; address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int k;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= DATA_W'(d);
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    k = 0;
    do begin
      @(posedge aclk);
      k++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && k < 100);
    s_axi_bready <= 1'b0;
    if (s_axi_bvalid !== 1'b1) begin
      err_count++;
      test_done();
    end
    chk_resp($sformatf("bresp at %h", a), er, s_axi_bresp);
  endtask : wr

  // One read; data kept in rd_v, compared only when asked
  task automatic rd(input logic [7:0] a, input logic [7:0] ex, input logic [1:0] er,
                    input bit cmp);
    int k;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    k = 0;
    do begin
      @(posedge aclk);
      k++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && k < 100);
    s_axi_rready <= 1'b0;
    if (s_axi_rvalid !== 1'b1) begin
      err_count++;
      test_done();
    end
    rd_v = s_axi_rdata;
    chk_resp($sformatf("rresp at %h", a), er, s_axi_rresp);
    if (cmp) chk_val($sformatf("rdata at %h", a), DATA_W'(ex), rd_v);
  endtask : rd

  // Preload a timer, low byte first so both halves land together
  task automatic load(input logic [7:0] lo, input logic [15:0] v);
    wr(lo, v[7:0], RESP_OKAY);
    wr(lo + 8'h04, v[15:8], RESP_OKAY);
  endtask : load

  // Bounded wait for the interrupt level; n counts the cycles spent
  task automatic wait_irq(input logic lvl, input int max);
    n = 0;
    while (irq !== lvl && n < max) begin
      @(posedge aclk);
      n++;
    end
    // A wait that runs out is a failure of its own
    if (irq !== lvl) begin
      err_count++;
      $display("wrong value irq level expected %0d seen %b", lvl, irq);
      test_done();
    end
  endtask : wait_irq

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values and unmapped places
    foreach (rst_ofs[i]) rd(rst_ofs[i], 8'h00, RESP_OKAY, 1);
    chk_val("irq after reset", 0, 32'(irq));
    rd(8'h24, 8'h00, RESP_DECERR, 1);
    wr(8'h28, 8'h11, RESP_DECERR);
    $display("test reset done");
    // Low byte buffer and read latch
    wr(OFS_A_LO, 8'h34, RESP_OKAY);
    rd(OFS_A_HI, 8'h00, RESP_OKAY, 1);
    rd(OFS_A_LO, 8'h00, RESP_OKAY, 1);
    wr(OFS_A_HI, 8'h12, RESP_OKAY);
    rd(OFS_A_HI, 8'h12, RESP_OKAY, 1);
    rd(OFS_A_LO, 8'h34, RESP_OKAY, 1);
    load(OFS_A_LO, 16'h5678);
    rd(OFS_A_LO, 8'h34, RESP_OKAY, 1);
    rd(OFS_A_HI, 8'h56, RESP_OKAY, 1);
    rd(OFS_A_LO, 8'h78, RESP_OKAY, 1);
    $display("test byte access done");
    wr(OFS_SW, 8'hA5, RESP_OKAY);
    chk_val("switch lines", 32'hA5, 32'(touch_switch_lines));
    rd(OFS_SW, 8'hA5, RESP_OKAY, 1);
    s_axi_wstrb <= 4'he;
    wr(OFS_SW, 8'h3C, RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(OFS_SW, 8'hA5, RESP_OKAY, 1);
    $display("test switch done");
    // Timer A overflow on the system clock raises the flag
    wr(OFS_CTRL, 8'h02, RESP_OKAY);
    wr(OFS_MASK, 8'h20, RESP_OKAY);
    load(OFS_A_LO, 16'hFFF0);
    load(OFS_B_LO, 16'h0000);
    osc_en <= 1'b1;
    wr(OFS_CLK, 8'h10, RESP_OKAY);
    wait_irq(1'b1, 100);
    chk_val("sys clock overflow time", 1, 32'(n < 24));
    rd(OFS_CLK, 8'h00, RESP_OKAY, 1);
    rd(OFS_A_HI, 8'h00, RESP_OKAY, 1);
    rd(OFS_A_LO, 8'h00, RESP_OKAY, 1);
    rd(OFS_B_HI, 8'h00, RESP_OKAY, 1);
    rd(OFS_B_LO, 8'h00, RESP_OKAY, 0);
    v2 = rd_v;
    chk_val("timer B counted", 1, 32'(v2 != 0));
    rd(OFS_B_HI, 8'h00, RESP_OKAY, 1);
    rd(OFS_B_LO, v2[7:0], RESP_OKAY, 1);
    chk_val("irq held", 1, 32'(irq));
    rd(OFS_STAT, 8'h20, RESP_OKAY, 1);
    wait_irq(1'b0, 5);
    chk_val("irq cleared", 0, 32'(irq));
    rd(OFS_STAT, 8'h00, RESP_OKAY, 1);
    $display("test timer A overflow done");
    // Divided clock, and timer bytes locked while running
    load(OFS_A_LO, 16'hFFF0);
    wr(OFS_CLK, 8'h30, RESP_OKAY);
    rd(OFS_A_HI, 8'h00, RESP_SLVERR, 1);
    wr(OFS_B_LO, 8'h55, RESP_SLVERR);
    wait_irq(1'b1, 200);
    chk_val("div4 overflow time", 1, 32'(n > 40 && n < 200));
    rd(OFS_CLK, 8'h20, RESP_OKAY, 1);
    rd(OFS_STAT, 8'h20, RESP_OKAY, 1);
    $display("test divided clock done");
    // Timer B selected: A overflow stops all but sets no flag
    wr(OFS_CTRL, 8'h03, RESP_OKAY);
    load(OFS_A_LO, 16'hFFF0);
    osc_en <= 1'b0;
    wr(OFS_CLK, 8'h10, RESP_OKAY);
    repeat (40) @(posedge aclk);
    chk_val("no flag from A", 0, 32'(irq));
    rd(OFS_CLK, 8'h00, RESP_OKAY, 1);
    rd(OFS_STAT, 8'h00, RESP_OKAY, 1);
    load(OFS_A_LO, 16'h0000);
    load(OFS_B_LO, 16'hFFFC);
    osc_en <= 1'b1;
    wr(OFS_CLK, 8'h10, RESP_OKAY);
    wait_irq(1'b1, 100);
    chk_val("flag from B", 1, 32'(irq));
    rd(OFS_B_HI, 8'h00, RESP_OKAY, 1);
    rd(OFS_B_LO, 8'h00, RESP_OKAY, 1);
    rd(OFS_A_HI, 8'h00, RESP_OKAY, 1);
    rd(OFS_A_LO, 8'h00, RESP_OKAY, 0);
    v2 = rd_v;
    rd(OFS_A_HI, 8'h00, RESP_OKAY, 1);
    rd(OFS_A_LO, v2[7:0], RESP_OKAY, 1);
    rd(OFS_STAT, 8'h20, RESP_OKAY, 1);
    $display("test timer B overflow done");
    // Disabled converter holds still; masked flag, then unmasked
    wr(OFS_CTRL, 8'h00, RESP_OKAY);
    wr(OFS_MASK, 8'h00, RESP_OKAY);
    load(OFS_A_LO, 16'hFFF0);
    wr(OFS_CLK, 8'h10, RESP_OKAY);
    repeat (40) @(posedge aclk);
    rd(OFS_CLK, 8'h10, RESP_OKAY, 1);
    wr(OFS_CTRL, 8'h02, RESP_OKAY);
    repeat (30) @(posedge aclk);
    rd(OFS_CLK, 8'h00, RESP_OKAY, 1);
    chk_val("irq masked", 0, 32'(irq));
    wr(OFS_MASK, 8'h20, RESP_OKAY);
    wait_irq(1'b1, 5);
    chk_val("irq unmasked", 1, 32'(irq));
    rd(OFS_STAT, 8'h20, RESP_OKAY, 1);
    wait_irq(1'b0, 5);
    chk_val("irq after read", 0, 32'(irq));
    $display("test enable and mask done");
    test_done();
  end
endmodule : rctc_top_tb

`default_nettype wire
